// [rtl/pie_consts.svh]
// Register indices, field positions, reset values and bus codes of the pin interrupt port.
`ifndef PIE_CONSTS_SVH
`define PIE_CONSTS_SVH

// Register indices; the byte address on the bus is four times the index.
`define PIE_IDX_EDGE_SEL_LO 16'hF038
`define PIE_IDX_EDGE_SEL_HI 16'hF039
`define PIE_IDX_SAMPLE_EN 16'hF03A
`define PIE_IDX_IRQ_STATUS 16'hF03B
`define PIE_IDX_IRQ_MASK 16'hF03C
`define PIE_IDX_PIN_LEVEL 16'hF20C
`define PIE_IDX_PULL_SEL_LO 16'hF20E
`define PIE_IDX_PULL_SEL_HI 16'hF20F

// Field layout of the eight interrupt lanes and the six port pins.
`define PIE_PORT_PINS 6
`define PIE_LANES 8
`define PIE_AUX_LSB 6
`define PIE_LANE_PWM_A 0
`define PIE_LANE_PWM_B 1
`define PIE_LANE_UART_A 2
`define PIE_LANE_UART_B 3

// Reset values.
`define PIE_RST_CFG 8'h00
`define PIE_RST_PULL 6'h00

// Bus answer codes and the least address width that reaches every register.
`define PIE_RESP_OKAY 2'h0
`define PIE_RESP_SLVERR 2'h2
`define PIE_MIN_ADDR_W 18

`endif

// [rtl/pie_pin_edge.sv]
// Edge detector of one interrupt lane, direct or on slow-tick samples.
`timescale 1ns/100ps
`default_nettype none

module pie_pin_edge (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic clk_en,
	input wire logic pin,
	input wire pie_pkg::pie_edge_t mode,
	input wire logic sample_en,
	input wire logic sample_stb,
	output logic level,
	output logic edge_evt
);
	import pie_pkg::*;

	logic sync_a;
	logic sync_b;
	logic prev_b;
	logic smp_last;
	logic qual;
	logic rise;
	logic fall;
	logic next_edge_evt;

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
			prev_b <= 1'b0;
		end else if (clk_en) begin
			sync_a <= pin;
			sync_b <= sync_a;
			prev_b <= sync_b;
		end
	end

	assign level = sync_b;

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			smp_last <= 1'b0;
			qual <= 1'b0;
		end else if (clk_en && sample_stb) begin
			smp_last <= sync_b;
			if (smp_last == sync_b && sync_b != qual) begin
				qual <= sync_b;
			end
		end
	end

	always_comb begin
		if (sample_en) begin
			rise = sample_stb & smp_last & sync_b & ~qual;
			fall = sample_stb & ~smp_last & ~sync_b & qual;
		end else begin
			rise = sync_b & ~prev_b;
			fall = ~sync_b & prev_b;
		end
	end

	always_comb begin
		unique case (mode)
			PIE_EDGE_OFF: next_edge_evt = 1'b0;
			PIE_EDGE_FALL: next_edge_evt = fall;
			PIE_EDGE_RISE: next_edge_evt = rise;
			PIE_EDGE_BOTH: next_edge_evt = rise | fall;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			edge_evt <= 1'b0;
		end else if (clk_en) begin
			edge_evt <= next_edge_evt;
		end
	end

	chk_off_stays_quiet: assert property (@(posedge mclk) disable iff (!nrst)
		clk_en && mode == PIE_EDGE_OFF |=> !edge_evt) else $error("event while disabled");

	chk_direct_fall_event: assert property (@(posedge mclk) disable iff (!nrst)
		clk_en && !sample_en && mode == PIE_EDGE_FALL && prev_b && !sync_b |=> edge_evt)
		else $error("direct falling edge missed");

	chk_sampled_rise_twice: assert property (@(posedge mclk) disable iff (!nrst)
		clk_en && sample_en && mode == PIE_EDGE_RISE && !(sample_stb && sync_b && smp_last)
		|=> !edge_evt) else $error("sampled rise without two high checks");

	chk_sampled_rise_next: assert property (@(posedge mclk) disable iff (!nrst)
		clk_en && sample_en && (mode == PIE_EDGE_RISE || mode == PIE_EDGE_BOTH) && sample_stb
		&& smp_last && sync_b && !qual |=> edge_evt)
		else $error("qualified sampled rise not raised on the next clock");

endmodule // pie_pin_edge

`default_nettype wire

// [rtl/pie_pkg.sv]
// Types shared by the pin interrupt port modules.
package pie_pkg;

	// Interrupt edge selection, high select bit then low select bit.
	typedef enum logic [1:0] {
		PIE_EDGE_OFF = 2'h0,
		PIE_EDGE_FALL = 2'h1,
		PIE_EDGE_RISE = 2'h2,
		PIE_EDGE_BOTH = 2'h3
	} pie_edge_t;

endpackage

// [rtl/pie_tick_sync.sv]
// Sampling strobe taken from falling edges of the slow tick.
`timescale 1ns/100ps
`default_nettype none

module pie_tick_sync (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic clk_en,
	input wire logic slow_sample_tick,
	input wire logic stop_mode,
	output logic sample_stb
);
	import pie_pkg::*;

	logic tick_q;

	// Last tick level, for the falling edge detector.
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			tick_q <= 1'b0;
		end else if (clk_en) begin
			tick_q <= slow_sample_tick;
		end
	end

	assign sample_stb = tick_q & ~slow_sample_tick & ~stop_mode;

	chk_stop_no_sample: assert property (@(posedge mclk) disable iff (!nrst)
		stop_mode |-> !sample_stb) else $error("sampling strobe seen in stop state");

endmodule // pie_tick_sync

`default_nettype wire

// [rtl/pie_top.sv]
// Six-pin input port with pull selection and eight edge interrupt lanes behind AXI4-Lite.
//
// Behaviour
// - Two pull bits per pin: 00 hi-z, 01 pull-down, 10 pull-up, 11 hi-z.
// - Reset clears all pull bits, so every pin starts high-impedance.
// - Software reads each port pin level from the read-only level register.
// - Two edge bits per pin: off, falling, rising, both; reset to zero.
// - Two aux pins use same encoding in top two bits of edge registers.
// - Per-lane sample enable: 0 direct detection, 1 detection on slow tick.
// - No sampling at all while the chip is in stop state.
// - Selected edge raises that lane's own request line, eight lines.
// - Each lane request is individually maskable by software.
// - Sampled rising mode needs high on two consecutive tick falling edges.
// - Request follows the second qualifying tick edge two clocks later.
// - Pins 0..3 also feed PWM event A, PWM event B, UART A, UART B.
`timescale 1ns/100ps
`default_nettype none
`include "pie_consts.svh"

module pie_top #(
	parameter int ADDR_W = `PIE_MIN_ADDR_W
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic clk_en,
	input wire logic [5:0] port_pin,
	input wire logic [1:0] aux_pin,
	input wire logic slow_sample_tick,
	input wire logic stop_mode,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [5:0] pull_up_en,
	output logic [5:0] pull_down_en,
	output logic [5:0] pin_irq_request,
	output logic [1:0] aux_pin_irq_request,
	output logic irq,
	output logic pwm_event_a_in,
	output logic pwm_event_b_in,
	output logic uart_a_rx_in,
	output logic uart_b_rx_in
);
	import pie_pkg::*;

	// The register indices need this many address bits.
	if (ADDR_W < `PIE_MIN_ADDR_W || ADDR_W > 32) begin : g_bad_addr_w
		$error("ADDR_W must lie between 18 and 32");
	end

	logic [7:0] ext_irq_edge_sel_lo;
	logic [7:0] ext_irq_edge_sel_hi;
	logic [7:0] ext_irq_sample_enable;
	logic [5:0] port_pull_sel_lo;
	logic [5:0] port_pull_sel_hi;
	logic [7:0] irq_status;
	logic [7:0] irq_mask;
	logic [7:0] next_irq_status;
	logic [7:0] next_irq_mask;
	logic [7:0] lane_pin;
	logic [7:0] lane_level;
	logic [7:0] lane_evt;
	logic sample_stb;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [7:0] w_byte_q;
	logic w_lane0_q;
	logic wr_fire;
	logic wr_en;
	logic [15:0] wr_idx;
	logic [15:0] rd_idx;
	logic wr_hit;
	logic rd_hit;
	logic [7:0] rd_byte;
	logic ar_fire;

	assign lane_pin = {aux_pin, port_pin};

	// One strobe per slow tick falling edge, silenced in stop state.
	pie_tick_sync u_tick (
		.mclk(mclk),
		.nrst(nrst),
		.clk_en(clk_en),
		.slow_sample_tick(slow_sample_tick),
		.stop_mode(stop_mode),
		.sample_stb(sample_stb)
	);

	for (genvar i = 0; i < `PIE_LANES; i++) begin : g_lane
		pie_pin_edge u_edge (
			.mclk(mclk),
			.nrst(nrst),
			.clk_en(clk_en),
			.pin(lane_pin[i]),
			.mode(pie_edge_t'({ext_irq_edge_sel_hi[i], ext_irq_edge_sel_lo[i]})),
			.sample_en(ext_irq_sample_enable[i]),
			.sample_stb(sample_stb),
			.level(lane_level[i]),
			.edge_evt(lane_evt[i])
		);
	end

	// Write address channel; awready low means an address is held.
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			s_axi_awready <= 1'b1;
			aw_addr_q <= '0;
		end else if (clk_en) begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				aw_addr_q <= s_axi_awaddr;
			end else if (wr_fire) begin
				s_axi_awready <= 1'b1;
			end
		end
	end

	// Write data channel; only the low byte lane carries register data.
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			s_axi_wready <= 1'b1;
			w_byte_q <= 8'h00;
			w_lane0_q <= 1'b0;
		end else if (clk_en) begin
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				w_byte_q <= s_axi_wdata[7:0];
				w_lane0_q <= s_axi_wstrb[0];
			end else if (wr_fire) begin
				s_axi_wready <= 1'b1;
			end
		end
	end

	// A write is carried out once both halves are held and no answer is pending.
	assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign wr_idx = aw_addr_q[17:2];
	assign wr_en = wr_fire && w_lane0_q;
	assign wr_hit = aw_addr_q[1:0] == 2'h0 && (aw_addr_q >> 18) == '0 && (
		wr_idx == `PIE_IDX_EDGE_SEL_LO || wr_idx == `PIE_IDX_EDGE_SEL_HI ||
		wr_idx == `PIE_IDX_SAMPLE_EN || wr_idx == `PIE_IDX_IRQ_STATUS ||
		wr_idx == `PIE_IDX_IRQ_MASK || wr_idx == `PIE_IDX_PIN_LEVEL ||
		wr_idx == `PIE_IDX_PULL_SEL_LO || wr_idx == `PIE_IDX_PULL_SEL_HI);

	// Write response; unmapped addresses answer with a slave error.
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `PIE_RESP_OKAY;
		end else if (clk_en) begin
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? `PIE_RESP_OKAY : `PIE_RESP_SLVERR;
			end else if (s_axi_bready && s_axi_bvalid) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			ext_irq_edge_sel_lo <= `PIE_RST_CFG;
			ext_irq_edge_sel_hi <= `PIE_RST_CFG;
			ext_irq_sample_enable <= `PIE_RST_CFG;
		end else if (clk_en && wr_en && wr_hit) begin
			if (wr_idx == `PIE_IDX_EDGE_SEL_LO) begin
				ext_irq_edge_sel_lo <= w_byte_q;
			end
			if (wr_idx == `PIE_IDX_EDGE_SEL_HI) begin
				ext_irq_edge_sel_hi <= w_byte_q;
			end
			if (wr_idx == `PIE_IDX_SAMPLE_EN) begin
				ext_irq_sample_enable <= w_byte_q;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			port_pull_sel_lo <= `PIE_RST_PULL;
			port_pull_sel_hi <= `PIE_RST_PULL;
		end else if (clk_en && wr_en && wr_hit) begin
			if (wr_idx == `PIE_IDX_PULL_SEL_LO) begin
				port_pull_sel_lo <= w_byte_q[5:0];
			end
			if (wr_idx == `PIE_IDX_PULL_SEL_HI) begin
				port_pull_sel_hi <= w_byte_q[5:0];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			pull_up_en <= 6'h00;
			pull_down_en <= 6'h00;
		end else if (clk_en) begin
			pull_up_en <= port_pull_sel_hi & ~port_pull_sel_lo;
			pull_down_en <= port_pull_sel_lo & ~port_pull_sel_hi;
		end
	end

	// Status bits are sticky; a new event wins over a write-one clear.
	always_comb begin
		next_irq_status = irq_status | lane_evt;
		next_irq_mask = irq_mask;
		if (wr_en && wr_hit && wr_idx == `PIE_IDX_IRQ_STATUS) begin
			next_irq_status = (irq_status & ~w_byte_q) | lane_evt;
		end
		if (wr_en && wr_hit && wr_idx == `PIE_IDX_IRQ_MASK) begin
			next_irq_mask = w_byte_q;
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			irq_status <= `PIE_RST_CFG;
			irq_mask <= `PIE_RST_CFG;
			irq <= 1'b0;
		end else if (clk_en) begin
			irq_status <= next_irq_status;
			irq_mask <= next_irq_mask;
			irq <= |(next_irq_status & next_irq_mask);
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			pin_irq_request <= 6'h00;
			aux_pin_irq_request <= 2'h0;
		end else if (clk_en) begin
			pin_irq_request <= lane_evt[5:0] & irq_mask[5:0];
			aux_pin_irq_request <= lane_evt[7:6] & irq_mask[7:6];
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			pwm_event_a_in <= 1'b0;
			pwm_event_b_in <= 1'b0;
			uart_a_rx_in <= 1'b0;
			uart_b_rx_in <= 1'b0;
		end else if (clk_en) begin
			pwm_event_a_in <= lane_level[`PIE_LANE_PWM_A];
			pwm_event_b_in <= lane_level[`PIE_LANE_PWM_B];
			uart_a_rx_in <= lane_level[`PIE_LANE_UART_A];
			uart_b_rx_in <= lane_level[`PIE_LANE_UART_B];
		end
	end

	// Read decode; reserved bits of the narrow registers read as zero.
	assign rd_idx = s_axi_araddr[17:2];
	assign ar_fire = s_axi_arvalid && s_axi_arready;
	always_comb begin
		rd_hit = s_axi_araddr[1:0] == 2'h0 && (s_axi_araddr >> 18) == '0;
		rd_byte = 8'h00;
		unique case (rd_idx)
			`PIE_IDX_EDGE_SEL_LO: rd_byte = ext_irq_edge_sel_lo;
			`PIE_IDX_EDGE_SEL_HI: rd_byte = ext_irq_edge_sel_hi;
			`PIE_IDX_SAMPLE_EN: rd_byte = ext_irq_sample_enable;
			`PIE_IDX_IRQ_STATUS: rd_byte = irq_status;
			`PIE_IDX_IRQ_MASK: rd_byte = irq_mask;
			`PIE_IDX_PIN_LEVEL: rd_byte = {2'h0, lane_level[5:0]};
			`PIE_IDX_PULL_SEL_LO: rd_byte = {2'h0, port_pull_sel_lo};
			`PIE_IDX_PULL_SEL_HI: rd_byte = {2'h0, port_pull_sel_hi};
			default: rd_hit = 1'b0;
		endcase
	end

	// Read channel; one read is under way at a time.
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `PIE_RESP_OKAY;
		end else if (clk_en) begin
			if (ar_fire) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
				s_axi_rresp <= rd_hit ? `PIE_RESP_OKAY : `PIE_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	chk_pull_up_decode: assert property (@(posedge mclk) disable iff (!nrst)
		clk_en |=> pull_up_en == $past(port_pull_sel_hi & ~port_pull_sel_lo))
		else $error("pull-up enable does not follow select bits");

	chk_pull_reset_hiz: assert property (@(posedge mclk)
		!nrst |=> port_pull_sel_lo == 6'h00 && port_pull_sel_hi == 6'h00)
		else $error("pull select not cleared by reset");

	chk_request_needs_mask: assert property (@(posedge mclk) disable iff (!nrst)
		|pin_irq_request |-> (pin_irq_request & ~$past(irq_mask[5:0])) == 6'h00)
		else $error("request raised on a masked lane");

	chk_event_sets_status: assert property (@(posedge mclk) disable iff (!nrst)
		clk_en && |lane_evt |=> (irq_status & $past(lane_evt)) == $past(lane_evt))
		else $error("event lost from status");

	chk_irq_tracks_status: assert property (@(posedge mclk) disable iff (!nrst)
		clk_en |=> irq == |(irq_status & irq_mask))
		else $error("interrupt level does not match status and mask");

	chk_uart_route: assert property (@(posedge mclk) disable iff (!nrst)
		clk_en |=> uart_a_rx_in == $past(lane_level[2]) && pwm_event_a_in == $past(lane_level[0]))
		else $error("alternate input routing wrong");

	chk_bvalid_after_both: assert property (@(posedge mclk) disable iff (!nrst)
		$rose(s_axi_bvalid) |-> $past(!s_axi_awready && !s_axi_wready))
		else $error("write answered before address and data");

	chk_read_level: assert property (@(posedge mclk) disable iff (!nrst)
		clk_en && ar_fire && s_axi_araddr == ADDR_W'({`PIE_IDX_PIN_LEVEL, 2'h0})
		|=> s_axi_rvalid && s_axi_rdata[7:0] == {2'h0, $past(lane_level[5:0])})
		else $error("pin level read wrong");

endmodule // pie_top

`default_nettype wire

// [verif/pie_pin_model.sv]
// Board-side model of the port pins, their pull resistors and the slow sampling tick.
`timescale 1ns/100ps
`default_nettype none

module pie_pin_model #(
	parameter int TICK_HALF = 8
) (
	input wire logic mclk,
	input wire logic [7:0] board_lvl,
	input wire logic [7:0] board_drv,
	input wire logic [5:0] pull_up_en,
	input wire logic [5:0] pull_down_en,
	output logic [5:0] port_pin,
	output logic [1:0] aux_pin,
	output logic slow_sample_tick
);
	logic [7:0] wire_lvl;
	logic float_lvl = 1'b0;
	logic tick_q = 1'b0;
	int tick_cnt = 0;

	// The tick runs free, so the block itself must ignore it in stop state.
	always @(posedge mclk) begin
		float_lvl <= ~float_lvl;
		tick_cnt <= (tick_cnt == TICK_HALF - 1) ? 0 : tick_cnt + 1;
		if (tick_cnt == TICK_HALF - 1) begin
			tick_q <= ~tick_q;
		end
	end

	always_comb begin
		wire_lvl = board_lvl;
		for (int i = 0; i < 6; i++) begin
			if (!board_drv[i]) begin
				wire_lvl[i] = pull_up_en[i] ? 1'b1 : (pull_down_en[i] ? 1'b0 : float_lvl);
			end
		end
		for (int i = 6; i < 8; i++) begin
			if (!board_drv[i]) begin
				wire_lvl[i] = float_lvl;
			end
		end
	end

	// Pins and tick as the block sees them.
	assign port_pin = wire_lvl[5:0];
	assign aux_pin = wire_lvl[7:6];
	assign slow_sample_tick = tick_q;
endmodule // pie_pin_model

`default_nettype wire

// [verif/pie_top_tb_top.sv]
// Self-checking bench of the pin interrupt port over its bus and its pins.
`timescale 1ns/100ps
`default_nettype none
`include "pie_consts.svh"

`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin fail_count++; \
	$display("mismatch at %0t: got %0h expected %0h", $time, (got), (exp)); end end

module pie_top_tb_top;
	localparam logic [17:0] A_ELO = {`PIE_IDX_EDGE_SEL_LO, 2'b00};
	localparam logic [17:0] A_EHI = {`PIE_IDX_EDGE_SEL_HI, 2'b00};
	localparam logic [17:0] A_SMP = {`PIE_IDX_SAMPLE_EN, 2'b00};
	localparam logic [17:0] A_STS = {`PIE_IDX_IRQ_STATUS, 2'b00};
	localparam logic [17:0] A_MSK = {`PIE_IDX_IRQ_MASK, 2'b00};
	localparam logic [17:0] A_LVL = {`PIE_IDX_PIN_LEVEL, 2'b00};
	localparam logic [17:0] A_PLO = {`PIE_IDX_PULL_SEL_LO, 2'b00};
	localparam logic [17:0] A_PHI = {`PIE_IDX_PULL_SEL_HI, 2'b00};
	localparam logic [17:0] REGS [8] = '{A_ELO, A_EHI, A_SMP, A_STS, A_MSK, A_LVL, A_PLO, A_PHI};
	localparam logic [1:0] OK = `PIE_RESP_OKAY;
	localparam logic [1:0] ERR = `PIE_RESP_SLVERR;
	logic mclk, nrst, clk_en, stop_mode, slow_sample_tick, irq;
	logic [17:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, aux_pin, aux_pin_irq_request, eb;
	logic [5:0] port_pin, pull_up_en, pull_down_en, pin_irq_request;
	logic [7:0] board_lvl, board_drv, req;
	logic pwm_event_a_in, pwm_event_b_in, uart_a_rx_in, uart_b_rx_in;
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	logic [39:0] iq[$];
	logic [33:0] er;
	logic [39:0] ei;
	logic [31:0] cyc = 32'h0;
	int fail_count = 0;
	int checks = 0;

	pie_top #(.ADDR_W(18)) i_dut (.mclk, .nrst, .clk_en, .port_pin, .aux_pin,
		.slow_sample_tick, .stop_mode, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pull_up_en,
		.pull_down_en, .pin_irq_request, .aux_pin_irq_request, .irq, .pwm_event_a_in,
		.pwm_event_b_in, .uart_a_rx_in, .uart_b_rx_in);

	pie_pin_model #(.TICK_HALF(8)) i_pins (.mclk, .board_lvl, .board_drv, .pull_up_en,
		.pull_down_en, .port_pin, .aux_pin, .slow_sample_tick);

	assign req = {aux_pin_irq_request, pin_irq_request};

	// Clock of 5 ns period.
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	// Prints the verdict and ends the run.
	task automatic wrap_up();
		if (fail_count == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Cycle count with a ceiling that cuts a hang short.
	always @(posedge mclk) begin
		cyc <= cyc + 32'd1;
		if (cyc == 32'd20000) begin
			fail_count++;
			wrap_up();
		end
	end

	// One bus write; address and data are offered together and released once taken.
	task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic [1:0] e);
		bit ad;
		bit wd;
		ad = 1'b0;
		wd = 1'b0;
		bq.push_back(e);
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge mclk);
			if (s_axi_awvalid && s_axi_awready) begin
				ad = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wd = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (!s_axi_bvalid) @(posedge mclk);
		s_axi_bready <= 1'b0;
	endtask

	// One bus read; the expected word and response go on the queue first.
	task automatic rd(input logic [17:0] a, input logic [31:0] d, input logic [1:0] e);
		rq.push_back({e, d});
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge mclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		while (!s_axi_rvalid) @(posedge mclk);
		s_axi_rready <= 1'b0;
	endtask

	// Notes a request pulse; an all-ones stamp means its cycle is not checked.
	task automatic ex_irq(input logic [31:0] st, input logic [7:0] v);
		if (v != 8'h00) iq.push_back({st, v});
	endtask

	// Takes the oldest note whenever a response or a request pulse shows up.
	always @(posedge mclk) begin
		if (s_axi_bvalid && s_axi_bready) begin
			eb = bq.size() ? bq.pop_front() : 2'bxx;
			`CHK(s_axi_bresp, eb)
		end
		if (s_axi_rvalid && s_axi_rready) begin
			er = rq.size() ? rq.pop_front() : 34'bx;
			`CHK({s_axi_rresp, s_axi_rdata}, er)
		end
		if (nrst && req !== 8'h00) begin
			ei = iq.size() ? iq.pop_front() : 40'bx;
			`CHK(req, ei[7:0])
			if (ei[39:8] !== 32'hFFFFFFFF) `CHK(cyc - ei[39:8], 32'd5)
		end
	end

	// Main sequence.
	initial begin
		logic [7:0] lo, hi, m, r, drv, ex;
		void'($urandom(28778));
		{nrst, stop_mode, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		clk_en = 1'b1;
		board_lvl = 8'h00;
		board_drv = 8'hFF;
		repeat (10) @(posedge mclk);
		nrst <= 1'b1;
		for (int i = 0; i < 8; i++) rd(REGS[i], 32'h0, OK);
		rd(18'h3C0F4, 32'h0, ERR);
		rd(A_ELO + 18'h1, 32'h0, ERR);
		wr(18'h3C0F4, 32'hFF, ERR);
		wr(A_LVL, 32'h3F, OK);
		rd(A_LVL, 32'h0, OK);
		s_axi_wstrb <= 4'h0;
		wr(A_ELO, 32'hFF, OK);
		s_axi_wstrb <= 4'hF;
		rd(A_ELO, 32'h0, OK);
		for (int it = 0; it < 4; it++) begin
			lo = 8'($urandom);
			hi = 8'($urandom);
			r = 8'($urandom);
			wr(A_PLO, {24'h0, lo}, OK);
			wr(A_PHI, {24'h0, hi}, OK);
			rd(A_PLO, {26'h0, lo[5:0]}, OK);
			rd(A_PHI, {26'h0, hi[5:0]}, OK);
			`CHK(pull_up_en, hi[5:0] & ~lo[5:0])
			`CHK(pull_down_en, lo[5:0] & ~hi[5:0])
			drv = {2'b11, ~(hi[5:0] ^ lo[5:0])};
			ex = (drv & r) | (~drv & {2'b00, hi[5:0] & ~lo[5:0]});
			board_drv <= drv;
			board_lvl <= r;
			repeat (4) @(posedge mclk);
			rd(A_LVL, {26'h0, ex[5:0]}, OK);
			`CHK({uart_b_rx_in, uart_a_rx_in, pwm_event_b_in, pwm_event_a_in}, ex[3:0])
		end
		board_lvl <= 8'h00;
		board_drv <= 8'hFF;
		// A reset in mid-run must bring the pull selection back to high impedance.
		nrst <= 1'b0;
		repeat (2) @(posedge mclk);
		nrst <= 1'b1;
		rd(A_PLO, 32'h0, OK);
		rd(A_PHI, 32'h0, OK);
		`CHK(pull_up_en, 6'h00)
		`CHK(pull_down_en, 6'h00)
		for (int it = 0; it < 4; it++) begin
			lo = it ? 8'($urandom) : 8'hAA;
			hi = it ? 8'($urandom) : 8'hCC;
			m = it ? 8'($urandom) : 8'hFF;
			wr(A_ELO, {24'h0, lo}, OK);
			wr(A_EHI, {24'h0, hi}, OK);
			wr(A_MSK, {24'h0, m}, OK);
			@(posedge mclk);
			board_lvl <= 8'hFF;
			ex_irq(cyc, hi & m);
			repeat (8) @(posedge mclk);
			board_lvl <= 8'h00;
			ex_irq(cyc, lo & m);
			repeat (8) @(posedge mclk);
			rd(A_STS, {24'h0, hi | lo}, OK);
			`CHK(irq, |((hi | lo) & m))
			wr(A_STS, 32'hFF, OK);
			rd(A_STS, 32'h0, OK);
			`CHK(irq, 1'b0)
		end
		// Lanes 0-3 both edges, lanes 4-5 falling, lanes 6-7 rising, all unmasked.
		wr(A_ELO, 32'h3F, OK);
		wr(A_EHI, 32'hCF, OK);
		wr(A_MSK, 32'hFF, OK);
		// A pin pulse that starts and ends while the clock enable is low leaves no event.
		clk_en <= 1'b0;
		board_lvl <= 8'hFF;
		repeat (6) @(posedge mclk);
		board_lvl <= 8'h00;
		repeat (2) @(posedge mclk);
		clk_en <= 1'b1;
		repeat (4) @(posedge mclk);
		rd(A_STS, 32'h0, OK);
		wr(A_SMP, 32'hFF, OK);
		@(posedge mclk);
		board_lvl <= 8'hFF;
		repeat (2) @(posedge mclk);
		board_lvl <= 8'h00;
		repeat (40) @(posedge mclk);
		board_lvl <= 8'hFF;
		ex_irq(32'hFFFFFFFF, 8'hCF);
		repeat (60) @(posedge mclk);
		board_lvl <= 8'h00;
		ex_irq(32'hFFFFFFFF, 8'h3F);
		repeat (60) @(posedge mclk);
		stop_mode <= 1'b1;
		repeat (4) @(posedge mclk);
		board_lvl <= 8'hFF;
		repeat (60) @(posedge mclk);
		board_lvl <= 8'h00;
		repeat (40) @(posedge mclk);
		stop_mode <= 1'b0;
		repeat (60) @(posedge mclk);
		`CHK(iq.size(), 0)
		wrap_up();
	end
endmodule // pie_top_tb_top

`default_nettype wire
